/* design/mhr_pkg.sv */
// constants and register map of the holding register read handler
package mhr_pkg;

    // ************************************************************
    // function codes and exception codes
    // ************************************************************
    localparam logic [7:0] FC_READ      = 8'h03;
    localparam logic [7:0] FC_WRITE     = 8'h10;
    localparam logic [7:0] FC_READWRITE = 8'h17;
    localparam logic [7:0] FC_EXC_FLAG  = 8'h80;
    localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    localparam logic [7:0] EXC_BAD_DATA = 8'h03;

    // ************************************************************
    // header field values and query limits
    // ************************************************************
    localparam logic [15:0] PROTO_MODBUS = 16'h0000;
    localparam logic [7:0]  UNIT_ZERO    = 8'h00;
    localparam logic [7:0]  UNIT_ALL     = 8'hFF;
    localparam logic [15:0] QUERY_LEN    = 16'h0006;
    localparam logic [15:0] CNT_MIN      = 16'h0001;
    localparam logic [15:0] CNT_MAX      = 16'h007D;
    localparam logic [15:0] RESP_FIXED   = 16'h0003;

    // ************************************************************
    // query and response byte layout
    // ************************************************************
    localparam logic [3:0] QUERY_LAST   = 4'h B;
    localparam int         Q_TID        = 80;
    localparam int         Q_PID        = 64;
    localparam int         Q_LEN        = 48;
    localparam int         Q_UNIT       = 40;
    localparam int         Q_FC         = 32;
    localparam int         Q_START      = 16;
    localparam int         Q_CNT        = 0;
    localparam logic [8:0] TX_TID_HI    = 9'h000;
    localparam logic [8:0] TX_TID_LO    = 9'h001;
    localparam logic [8:0] TX_PID_HI    = 9'h002;
    localparam logic [8:0] TX_PID_LO    = 9'h003;
    localparam logic [8:0] TX_LEN_HI    = 9'h004;
    localparam logic [8:0] TX_LEN_LO    = 9'h005;
    localparam logic [8:0] TX_UNIT      = 9'h006;
    localparam logic [8:0] TX_FC        = 9'h007;
    localparam logic [8:0] TX_COUNT     = 9'h008;
    localparam logic [8:0] TX_HDR_BYTES = 9'h009;

    // ************************************************************
    // monitor register map (read only)
    // ************************************************************
    localparam int          MAP_WORDS   = 28;
    localparam logic [15:0] MAP_FIRST   = 16'h011C;
    localparam logic [15:0] MAP_LAST    = 16'h0137;
    localparam logic [15:0] REG_REMOTE_OUTPUT_BITS      = 16'h011C;
    localparam logic [15:0] REG_SELECTED_OP_NUMBER_ECHO = 16'h011D;
    localparam logic [15:0] REG_FIXED_OUTPUT_BITS       = 16'h011E;
    localparam logic [15:0] REG_CURRENT_ALARM_CODE      = 16'h011F;
    localparam logic [15:0] REG_MEASURED_POSITION_LOW   = 16'h0120;
    localparam logic [15:0] REG_MEASURED_POSITION_HIGH  = 16'h0121;
    localparam logic [15:0] REG_MEASURED_SPEED_LOW      = 16'h0122;
    localparam logic [15:0] REG_MEASURED_SPEED_HIGH     = 16'h0123;
    localparam logic [15:0] REG_TARGET_POSITION_LOW     = 16'h0124;
    localparam logic [15:0] REG_TARGET_POSITION_HIGH    = 16'h0125;
    localparam logic [15:0] REG_LOAD_TORQUE_LEVEL       = 16'h0126;
    localparam logic [15:0] REG_DRIVE_CURRENT_SETTING   = 16'h0127;
    localparam logic [15:0] REG_NOTICE_FLAGS_LOW        = 16'h0128;
    localparam logic [15:0] REG_NOTICE_FLAGS_HIGH       = 16'h0129;
    localparam logic [15:0] REG_RESERVED_WORD           = 16'h012A;
    localparam logic [15:0] REG_PARAMETER_READ_ID_ECHO  = 16'h012B;
    localparam logic [15:0] REG_PARAMETER_ACCESS_STATE  = 16'h012C;
    localparam logic [15:0] REG_PARAMETER_WRITE_ID_ECHO = 16'h012D;
    localparam logic [15:0] REG_PARAMETER_VALUE_LOW     = 16'h012E;
    localparam logic [15:0] REG_PARAMETER_VALUE_HIGH    = 16'h012F;
    localparam logic [15:0] REG_SELECTABLE_WATCH0_LOW   = 16'h0130;
    localparam logic [15:0] REG_SELECTABLE_WATCH0_HIGH  = 16'h0131;
    localparam logic [15:0] REG_SELECTABLE_WATCH1_LOW   = 16'h0132;
    localparam logic [15:0] REG_SELECTABLE_WATCH1_HIGH  = 16'h0133;
    localparam logic [15:0] REG_SELECTABLE_WATCH2_LOW   = 16'h0134;
    localparam logic [15:0] REG_SELECTABLE_WATCH2_HIGH  = 16'h0135;
    localparam logic [15:0] REG_SELECTABLE_WATCH3_LOW   = 16'h0136;
    localparam logic [15:0] REG_SELECTABLE_WATCH3_HIGH  = 16'h0137;

    // ************************************************************
    // handler states
    // ************************************************************
    typedef enum logic [1:0] {
        MHR_IDLE,
        MHR_COLLECT,
        MHR_CHECK,
        MHR_SEND
    } mhr_state_e;

endpackage

/* design/mhr_snap.sv */
// snapshot bank that freezes all monitor words at one instant
`timescale 1ns/1ns
module mhr_snap
    import mhr_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      ce,
    input  wire logic                      take,
    input  wire logic [MAP_WORDS*16-1:0]   mon_words,
    output logic      [MAP_WORDS*16-1:0]   snap_words
);

    // ************************************************************
    // one holding flop word per monitor register
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < MAP_WORDS; g = g + 1) begin : g_word
            // every word loads on the same take pulse
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    snap_words[g*16 +: 16] <= 16'h0000;
                end else if (ce && take) begin
                    snap_words[g*16 +: 16] <= mon_words[g*16 +: 16];
                end
            end
        end
    endgenerate

endmodule

/* design/mhr_pick.sv */
// selects one byte of one frozen monitor word
`timescale 1ns/1ns
module mhr_pick
    import mhr_pkg::*;
(
    input  wire logic [MAP_WORDS*16-1:0]   snap_words,
    input  wire logic [4:0]                word_idx,
    input  wire logic                      upper,
    output logic      [7:0]                byte_out
);

    // ************************************************************
    // word and byte selection
    // ************************************************************
    logic [15:0] word_sel;   // addressed word

    // out-of-map index cannot occur: the range is checked first
    assign word_sel = snap_words[word_idx*16 +: 16];
    // upper byte goes out first, lower byte second
    assign byte_out = upper ? word_sel[15:8] : word_sel[7:0];

endmodule

/* design/mhr_reader.sv */
// read holding registers handler: parse query, build response bytes
//
// Operation
// RULE1: refuse unsupported function codes, never execute them
// RULE2: client reads both 32-bit halves together
// RULE3: return registers ascending from first address
// RULE4: query is 03h, address, count, length 6
// RULE5: byte count equals twice register count
// RULE6: length field counts unit, code, data bytes
// RULE7: echo transaction, protocol, unit; return 03h
// RULE8: each register sent upper byte first
// RULE9: 32-bit quantity: low even, high next
// RULE10: reserved word may read any value
// RULE11: monitor map spans 011Ch through 0137h
// RULE12: register count must be 1 to 125
// RULE13: failed read answers code plus 80h, exception
// RULE14: address outside map gives exception 02h
// RULE15: latch all requested words at one instant
`timescale 1ns/1ns
module mhr_reader
    import mhr_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      ce,
    input  wire logic [7:0]                rx_data,
    input  wire logic                      rx_valid,
    input  wire logic                      rx_first,
    output logic                           rx_ready_r,
    output logic      [7:0]                tx_data_r,
    output logic                           tx_valid_r,
    output logic                           tx_last_r,
    input  wire logic                      tx_ready,
    input  wire logic [MAP_WORDS*16-1:0]   mon_words
);

    // ************************************************************
    // state and storage
    // ************************************************************
    mhr_state_e  state_r;          // handler state
    mhr_state_e  state_nxt;        // next handler state
    logic [95:0] query_r;          // query bytes, oldest in the top
    logic [3:0]  rx_cnt_r;         // query bytes taken so far
    logic        exc_r;            // response is an exception
    logic [7:0]  exc_code_r;       // exception code to send
    logic [8:0]  tx_idx_r;         // next response byte index
    logic [8:0]  tx_total_r;       // response bytes in all
    logic        snap_take;        // freeze the monitor words
    logic [MAP_WORDS*16-1:0] snap_words;   // frozen monitor words

    // ************************************************************
    // query fields
    // ************************************************************
    logic [15:0] q_tid;            // transaction identifier
    logic [15:0] q_pid;            // protocol identifier
    logic [15:0] q_len;            // message length field
    logic [7:0]  q_unit;           // unit identifier
    logic [7:0]  q_fc;             // function code
    logic [15:0] q_start;          // first register address
    logic [15:0] q_cnt;            // number of registers

    assign q_tid   = query_r[Q_TID   +: 16];
    assign q_pid   = query_r[Q_PID   +: 16];
    assign q_len   = query_r[Q_LEN   +: 16];
    assign q_unit  = query_r[Q_UNIT  +: 8];
    assign q_fc    = query_r[Q_FC    +: 8];
    assign q_start = query_r[Q_START +: 16];
    assign q_cnt   = query_r[Q_CNT   +: 16];

    // ************************************************************
    // receive side decode
    // ************************************************************
    logic rx_take;                 // a query byte is accepted
    logic rx_done;                 // this byte completes the query

    // bytes are taken only while the handler waits for a query
    assign rx_take = ce && rx_valid && rx_ready_r &&
                     (rx_first || state_r == MHR_COLLECT);
    assign rx_done = rx_take && !rx_first && rx_cnt_r == QUERY_LAST;

    // ************************************************************
    // query checks
    // ************************************************************
    logic        hdr_ok;           // protocol and unit acceptable
    logic        fc_read;          // read holding registers
    logic        fc_elsewhere;     // write or read/write code
    logic        len_ok;           // length field matches a read
    logic        drop;             // discard with no response
    logic        cnt_bad;          // register count out of range
    logic [16:0] end_addr;         // last requested address
    logic        addr_bad;         // a requested address unmapped
    logic [7:0]  exc_code_nxt;     // exception code chosen

    assign hdr_ok = q_pid == PROTO_MODBUS &&
                    (q_unit == UNIT_ZERO || q_unit == UNIT_ALL);
    assign fc_read      = q_fc == FC_READ;
    assign fc_elsewhere = q_fc == FC_WRITE || q_fc == FC_READWRITE;
    // RULE4: read query length
    assign len_ok = q_len == QUERY_LEN;
    // write and read/write queries belong to another handler
    assign drop = !hdr_ok || fc_elsewhere || (fc_read && !len_ok);
    // RULE12: count limits
    assign cnt_bad = q_cnt < CNT_MIN || q_cnt > CNT_MAX;
    // sum is one bit wider so a wrap cannot pass the check
    assign end_addr = {1'b0, q_start} + {1'b0, q_cnt} - 17'h0_0001;
    // RULE11: mapped window
    assign addr_bad = q_start < MAP_FIRST ||
                      end_addr > {1'b0, MAP_LAST};

    // RULE1: unsupported code
    assign exc_code_nxt = !fc_read ? EXC_BAD_FUNC :
                          cnt_bad  ? EXC_BAD_DATA :
                          // RULE14: address exception
                          addr_bad ? EXC_BAD_ADDR : 8'h00;

    // ************************************************************
    // response sizes
    // ************************************************************
    logic [7:0]  byte_cnt;         // data bytes in a normal answer
    logic [15:0] resp_len;         // length field of the response
    logic [8:0]  total_nxt;        // response bytes to send

    // RULE5: byte count
    assign byte_cnt = {q_cnt[6:0], 1'b0};
    // RULE6: length after the field
    assign resp_len = exc_r ? RESP_FIXED
                            : RESP_FIXED + {8'h00, byte_cnt};
    assign total_nxt = (exc_code_nxt != 8'h00) ? TX_HDR_BYTES
                     : TX_HDR_BYTES + {1'b0, byte_cnt};

    // ************************************************************
    // response byte selection
    // ************************************************************
    logic [8:0]  data_off;         // offset into the data bytes
    logic [15:0] word_addr;        // register for this data byte
    logic [15:0] word_rel;         // register relative to map
    logic [7:0]  data_byte;        // byte taken from frozen word
    logic [7:0]  tx_byte;          // byte for index tx_idx_r
    logic        tx_step;          // next byte may be presented
    logic        tx_end;           // all bytes presented

    assign data_off  = tx_idx_r - TX_HDR_BYTES;
    // RULE3: ascending address walk
    assign word_addr = q_start + {8'h00, data_off[8:1]};
    // RULE9: low half at even address
    assign word_rel  = word_addr - MAP_FIRST;

    // RULE8: upper byte on even offset
    mhr_pick u_pick (
        .snap_words (snap_words),
        .word_idx   (word_rel[4:0]),
        .upper      (!data_off[0]),
        .byte_out   (data_byte)
    );

    // RULE7: echoed header fields
    assign tx_byte =
        (tx_idx_r == TX_TID_HI) ? q_tid[15:8]  :
        (tx_idx_r == TX_TID_LO) ? q_tid[7:0]   :
        (tx_idx_r == TX_PID_HI) ? q_pid[15:8]  :
        (tx_idx_r == TX_PID_LO) ? q_pid[7:0]   :
        (tx_idx_r == TX_LEN_HI) ? resp_len[15:8] :
        (tx_idx_r == TX_LEN_LO) ? resp_len[7:0]  :
        (tx_idx_r == TX_UNIT)   ? q_unit       :
        // RULE13: exception function code
        (tx_idx_r == TX_FC)     ? (exc_r ? (q_fc | FC_EXC_FLAG) : q_fc) :
        (tx_idx_r == TX_COUNT)  ? (exc_r ? exc_code_r : byte_cnt) :
        data_byte;

    // a new byte goes out when the slot is empty or being taken
    assign tx_step = ce && state_r == MHR_SEND &&
                     (!tx_valid_r || tx_ready);
    assign tx_end  = tx_idx_r == tx_total_r;

    // ************************************************************
    // snapshot of the monitor words
    // ************************************************************
    // RULE15: one-instant latch
    assign snap_take = state_r == MHR_CHECK && !drop &&
                       exc_code_nxt == 8'h00;

    // RULE10: reserved word passed as is
    mhr_snap u_snap (
        .clk        (clk),
        .rst_b      (rst_b),
        .ce         (ce),
        .take       (snap_take),
        .mon_words  (mon_words),
        .snap_words (snap_words)
    );

    // ************************************************************
    // state machine next state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // wait for the first byte of a query
            MHR_IDLE: begin
                if (rx_take) begin
                    state_nxt = MHR_COLLECT;
                end
            end
            // gather the remaining query bytes
            MHR_COLLECT: begin
                if (rx_done) begin
                    state_nxt = MHR_CHECK;
                end
            end
            // judge the query, drop or answer
            MHR_CHECK: begin
                if (drop) begin
                    state_nxt = MHR_IDLE;
                end else begin
                    state_nxt = MHR_SEND;
                end
            end
            // stream the response out
            MHR_SEND: begin
                if (tx_step && tx_end) begin
                    state_nxt = MHR_IDLE;
                end
            end
            default: begin
                state_nxt = MHR_IDLE;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= MHR_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // query capture
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            query_r  <= 96'h0;
            rx_cnt_r <= 4'h0;
        end else if (rx_take) begin
            // a first byte always restarts the query
            query_r  <= {query_r[87:0], rx_data};
            rx_cnt_r <= rx_first ? 4'h1 : rx_cnt_r + 4'h1;
        end
    end

    // ************************************************************
    // receive ready: only one query handled at a time
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_ready_r <= 1'b1;
        end else if (ce) begin
            rx_ready_r <= state_nxt == MHR_IDLE ||
                          state_nxt == MHR_COLLECT;
        end
    end

    // ************************************************************
    // decision latch
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exc_r      <= 1'b0;
            exc_code_r <= 8'h00;
            tx_total_r <= 9'h000;
        end else if (ce && state_r == MHR_CHECK) begin
            exc_r      <= exc_code_nxt != 8'h00;
            exc_code_r <= exc_code_nxt;
            tx_total_r <= total_nxt;
        end
    end

    // ************************************************************
    // response byte index
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_idx_r <= 9'h000;
        end else if (ce && state_r == MHR_CHECK) begin
            tx_idx_r <= 9'h000;
        end else if (tx_step && !tx_end) begin
            tx_idx_r <= tx_idx_r + 9'h001;
        end
    end

    // ************************************************************
    // response byte output
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_data_r  <= 8'h00;
            tx_valid_r <= 1'b0;
            tx_last_r  <= 1'b0;
        end else if (tx_step) begin
            // present the next byte, or empty the slot at the end
            tx_data_r  <= tx_end ? 8'h00 : tx_byte;
            tx_valid_r <= !tx_end;
            tx_last_r  <= !tx_end && tx_idx_r == tx_total_r - 9'h001;
        end
    end

endmodule

/* test/mhr_checker.sv */
// response framing checker for the holding register read handler
`timescale 1ns/1ns
module mhr_checker
    import mhr_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       ce,
    input wire logic       rx_ready_r,
    input wire logic [7:0] tx_data_r,
    input wire logic       tx_valid_r,
    input wire logic       tx_last_r,
    input wire logic       tx_ready
);
    // ****
    // byte position tracking
    // ****
    logic       acc;    // response byte taken at this edge
    logic [8:0] idx_r;  // position of the byte on offer
    logic [7:0] len_r;  // low byte of the length field
    logic [7:0] fc_r;   // function code that was sent
    logic [7:0] cnt_r;  // byte count or exception code sent
    assign acc = ce && tx_valid_r && tx_ready;
    // capture header fields
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_r <= 9'h000;
            len_r <= 8'h00;
            fc_r  <= 8'h00;
            cnt_r <= 8'h00;
        end else if (acc) begin
            idx_r <= tx_last_r ? 9'h000 : idx_r + 9'h001;
            if (idx_r == TX_LEN_LO) len_r <= tx_data_r;
            if (idx_r == TX_FC) fc_r <= tx_data_r;
            if (idx_r == TX_COUNT) cnt_r <= tx_data_r;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ****
    // assertions
    // ****
    hold_stall_a: assert property (
        tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
        else $error("byte changed during stall");
    last_valid_a: assert property (tx_last_r |-> tx_valid_r)
        else $error("last without valid");
    busy_quiet_a: assert property (tx_valid_r |-> !rx_ready_r)
        else $error("query taken while answering");
    proto_zero_a: assert property (
        acc && (idx_r == TX_PID_HI || idx_r == TX_PID_LO) |-> tx_data_r == 0)
        else $error("protocol id not echoed");
    len_match_a: assert property (
        acc && tx_last_r |-> idx_r == {1'b0, len_r} + 9'h005)
        else $error("length field wrong");
    count_match_a: assert property (
        acc && tx_last_r && fc_r == FC_READ |-> idx_r == {1'b0, cnt_r} + 9'h008)
        else $error("byte count wrong");
    exc_short_a: assert property (
        acc && tx_last_r && fc_r[7] |-> idx_r == TX_COUNT && len_r == 8'h03)
        else $error("exception size wrong");
    exc_code_a: assert property (
        acc && idx_r == TX_COUNT && fc_r[7] |-> tx_data_r inside {[1:3]})
        else $error("exception code out of set");
    fc_kind_a: assert property (
        acc && idx_r == TX_FC |-> tx_data_r == FC_READ || tx_data_r[7])
        else $error("unsupported code executed");
    cover property (acc && tx_last_r && fc_r == FC_READ);
    cover property (acc && tx_last_r && fc_r[7]);
    cover property (tx_valid_r && !tx_ready);
endmodule

/* test/mhr_client.sv */
// network client model: sends queries and gathers response bytes
`timescale 1ns/1ns
module mhr_client (
    input  wire logic       clk,
    input  wire logic       rx_ready_r,
    input  wire logic [7:0] tx_data_r,
    input  wire logic       tx_valid_r,
    input  wire logic       tx_last_r,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_first,
    output logic            tx_ready
);
    logic       slow = 1'b0; // drop ready on every other clock
    logic       done = 1'b0; // last response byte taken
    logic [7:0] resp[$];     // response bytes gathered
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        rx_first = 1'b0;
        tx_ready = 1'b1;
    end
    // whole query, fields upper byte first
    task automatic send(input logic [95:0] q);
        @(posedge clk);
        #1;
        for (int i = 11; i >= 0; i--) begin
            rx_data  = q[i*8 +: 8];
            rx_first = (i == 11);
            rx_valid = 1'b1;
            while (!rx_ready_r) begin
                @(posedge clk);
                #1;
            end
            @(posedge clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_data  = ~rx_data; // released line shows no stale byte
    endtask
    // take response bytes, stalling when slow
    always @(posedge clk) begin
        if (tx_valid_r && tx_ready) begin
            resp.push_back(tx_data_r);
            if (tx_last_r) done = 1'b1;
        end
        #1 tx_ready = slow ? ~tx_ready : 1'b1;
    end
endmodule

/* test/tb_mhr_reader.sv */
// testbench of the holding register read handler
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_mhr_reader
    import mhr_pkg::*;
();
    logic                   clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   ce = 1'b1;
    logic [MAP_WORDS*16-1:0] mon_words;
    logic [7:0]             rx_data;
    logic [7:0]             tx_data_r;
    logic                   rx_valid, rx_first, rx_ready_r;
    logic                   tx_valid_r, tx_last_r, tx_ready;
    int                     n_mismatch = 0;
    int                     checks_done = 0;
    always #5 clk = ~clk;
    mhr_reader mhr_reader_inst (.clk, .rst_b, .ce, .rx_data, .rx_valid,
        .rx_first, .rx_ready_r, .tx_data_r, .tx_valid_r, .tx_last_r,
        .tx_ready, .mon_words);
    mhr_client cli (.clk, .rx_ready_r, .tx_data_r, .tx_valid_r,
        .tx_last_r, .rx_data, .rx_valid, .rx_first, .tx_ready);
    // one query and its whole answer; exc 0: normal
    task automatic xfer(input logic [15:0] tid, input logic [7:0] unit,
        input logic [7:0] fc, input logic [15:0] start, input logic [15:0] n,
        input logic [7:0] exc);
        logic [7:0]              e[$];
        logic [MAP_WORDS*16-1:0] snap;
        logic [15:0]             w;
        snap = mon_words;
        cli.resp.delete();
        cli.done = 1'b0;
        cli.send({tid, PROTO_MODBUS, QUERY_LEN, unit, fc, start, n});
        repeat (4) @(posedge clk);
        #1 mon_words = ~mon_words; // later changes must not leak in
        e = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00,
            exc != 0 ? 8'h03 : 8'(2 * n + 3), unit,
            exc != 0 ? fc | FC_EXC_FLAG : fc, exc != 0 ? exc : 8'(2 * n)};
        for (int k = 0; k < n && exc == 0; k++) begin
            w = snap[16 * (start - MAP_FIRST + k) +: 16];
            e.push_back(w[15:8]);
            e.push_back(w[7:0]);
        end
        for (int i = 0; i < 3000 && !cli.done; i++) @(posedge clk);
        `CHK(cli.done, 1'b1)
        `CHK(cli.resp.size(), e.size())
        foreach (e[i])
            if (i < 9 || start + (i - 9) / 2 != REG_RESERVED_WORD)
                `CHK(cli.resp[i], e[i])
    endtask
    // query that gets no response
    task automatic drop(input logic [95:0] q);
        cli.resp.delete();
        cli.send(q);
        repeat (30) @(posedge clk);
        `CHK(cli.resp.size(), 0)
    endtask
    task automatic t_full_map();
        cli.slow = 1'b1;
        xfer(16'hA55A, UNIT_ALL, FC_READ, MAP_FIRST, 16'd28, 8'h00);
        cli.slow = 1'b0;
        xfer(16'h5AA5, UNIT_ZERO, FC_READ, 16'h0130, 16'd8, 8'h00);
    endtask
    task automatic t_edges();
        xfer(16'h0001, UNIT_ZERO, FC_READ, MAP_LAST, 16'd1, 8'h00);
        xfer(16'h0002, UNIT_ZERO, FC_READ, 16'h0136, 16'd3, EXC_BAD_ADDR);
        xfer(16'h0003, UNIT_ZERO, FC_READ, 16'h011B, 16'd1, EXC_BAD_ADDR);
        xfer(16'h0010, UNIT_ZERO, FC_READ, MAP_FIRST, 16'd0, EXC_BAD_DATA);
        xfer(16'h0011, UNIT_ZERO, FC_READ, MAP_FIRST, 16'd126, EXC_BAD_DATA);
        xfer(16'h0012, UNIT_ZERO, FC_READ, MAP_FIRST, 16'd125, EXC_BAD_ADDR);
    endtask
    task automatic t_bad_function();
        logic [7:0] codes[4] = '{8'h01, 8'h04, 8'h06, 8'h7F};
        foreach (codes[i])
            xfer(16'h0020, UNIT_ZERO, codes[i], MAP_FIRST, 16'd1, EXC_BAD_FUNC);
    endtask
    task automatic t_dropped();
        drop({16'h0030, 16'h0001, QUERY_LEN, UNIT_ZERO, FC_READ, MAP_FIRST, 16'd1});
        drop({16'h0031, PROTO_MODBUS, QUERY_LEN, 8'h05, FC_READ, MAP_FIRST, 16'd1});
        drop({16'h0032, PROTO_MODBUS, QUERY_LEN, UNIT_ZERO, FC_WRITE, 32'h011C0001});
        xfer(16'h0033, UNIT_ZERO, FC_READ, 16'h0128, 16'd4, 8'h00);
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        for (int k = 0; k < MAP_WORDS; k++)
            mon_words[16*k +: 16] = 16'h1E20 + 16'(k * 16'h0107);
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        t_full_map();
        t_edges();
        t_bad_function();
        t_dropped();
        give_verdict();
    end
    // watchdog against a hung handshake
    initial begin
        #300000;
        n_mismatch++;
        give_verdict();
    end
endmodule
bind mhr_reader mhr_checker mhr_checker_inst (.clk, .rst_b, .ce,
    .rx_ready_r, .tx_data_r, .tx_valid_r, .tx_last_r, .tx_ready);
